//--- core/pmcs_cfg.svh
// Constants for the power management control and status register
`ifndef PMCS_CFG_SVH
`define PMCS_CFG_SVH
`define PMCS_REG_OFFSET     12'h0A4
`define PMCS_RESET_VALUE    32'h0000_0008
`define PMCS_STATE_LSB      0
`define PMCS_STATE_MSB      1
`define PMCS_NOSOFT_BIT     3
`define PMCS_WAKE_EN_BIT    8
`define PMCS_WAKE_ST_BIT    15
`define PMCS_STATE_D0       2'h0
`define PMCS_STATE_D1       2'h1
`define PMCS_STATE_D2       2'h2
`define PMCS_STATE_D3HOT    2'h3
`define PMCS_WAKE_EN_RESET  1'h0
`define PMCS_ZERO_WORD      32'h0000_0000
`define PMCS_NOSOFT_VALUE   1'h1
`define PMCS_LANE_STATE     0
`define PMCS_LANE_WAKE      1
`define PMCS_DATA_MSB       31
`define PMCS_DATA_LSB       24
`define PMCS_RSVD_HI_MSB    23
`define PMCS_RSVD_HI_LSB    16
`define PMCS_SCALE_MSB      14
`define PMCS_SCALE_LSB      13
`define PMCS_SELECT_MSB     12
`define PMCS_SELECT_LSB     9
`define PMCS_RSVD_LO_MSB    7
`define PMCS_RSVD_LO_LSB    4
`define PMCS_RSVD_BIT       2
`endif

//--- core/pmcs_pkg.sv
// Types for the power management control and status register
package pmcs_pkg;
    typedef struct packed {
        logic [1:0] power_state_field;
        logic       wake_event_enable;
    } pmcs_state_type;

    typedef struct packed {
        logic        wr_en;
        logic        rd_en;
        logic [11:0] addr;
        logic [3:0]  byte_en;
        logic [31:0] wdata;
    } pmcs_cfg_req_type;
endpackage

//--- core/pmcs_power_state_control.sv
// Power management control and status register with power state and wake enable
//
// Functional notes
// R1 - Bits 1:0 read the current power state and a write there requests a new state.
// R2 - A write requesting an unsupported state is ignored and the old state stays.
// R3 - D1 and D2 are unsupported, so only D0 and D3hot are accepted.
// R4 - Bit 8 is a read-write wake event enable that gates the wake event signal; here it is only stored and driven out on wake_event_enable.
// R5 - Wake enable clears after power-off and keeps its value across a D3cold wake.
// R6 - Wake event status bit 15 always reads 0.
// R7 - Skip-soft-reset flag bit 3 always reads 1.
// R8 - Power data byte 31:24 always reads 0x00.
// R9 - Data scale 14:13 and data select 12:9 read zero and are read-only.
// R10 - Reserved bits 23:16, 7:4 and 2 read zero.
// R11 - After reset the register reads 0x0000_0008.
// R12 - Writes update only the power state field and the wake enable bit.
//
// Usage
// - cold_wake must stand high for the whole reset when the device comes back from D3cold;
//   outside reset it is ignored.
// - Byte lane 0 gates the power state field and lane 1 the wake enable, so a partial write
//   touches only the lanes it enables.
// - A read and a write to this offset in one cycle return the value held before the write.
// - Any other offset reads as zero and ignores writes; the neighbouring capability words
//   live elsewhere.
// - Refused state requests are dropped silently: software must read back to see whether
//   the transition happened.
// - The wake enable is only stored here; the wake signalling itself sits outside this block.
// - Read data is registered and holds until the next read or reset, so a slow host may sample late.
`timescale 1ns/10ps
`include "pmcs_cfg.svh"

module pmcs_power_state_control (
    input  wire logic                      sys_clk,
    input  wire logic                      reset,
    input  wire logic                      cold_wake,
    input  wire pmcs_pkg::pmcs_cfg_req_type cfg_req,
    output logic [31:0]                    cfg_rdata,
    output logic                           cfg_rvalid,
    output logic [1:0]                     power_state_field,
    output logic                           wake_event_enable
);

    // ==========================================================
    // State
    typedef struct packed {
        pmcs_pkg::pmcs_state_type pm;
        logic [31:0]              rdata;
        logic                     rvalid;
    } pmcs_all_type;

    pmcs_all_type state_reg;
    pmcs_all_type state_next;
    logic         hit;
    logic [31:0]  image;
    logic [1:0]   req_state;

    assign hit       = (cfg_req.addr == `PMCS_REG_OFFSET);
    assign req_state = cfg_req.wdata[`PMCS_STATE_MSB:`PMCS_STATE_LSB];

    // ==========================================================
    // Read image: all fixed fields are constants
    always_comb begin
        image = '0; // R6 R8 R9 R10
        image[`PMCS_NOSOFT_BIT] = `PMCS_NOSOFT_VALUE; // R7
        image[`PMCS_STATE_MSB:`PMCS_STATE_LSB] = state_reg.pm.power_state_field; // R1
        image[`PMCS_WAKE_EN_BIT] = state_reg.pm.wake_event_enable; // R4
    end

    // ==========================================================
    // Next state
    always_comb begin
        state_next        = state_reg;
        state_next.rvalid = 1'h0;
        if (cfg_req.wr_en && hit) begin
            // Only writable fields are taken; the rest of the word is dropped
            if (cfg_req.byte_en[`PMCS_LANE_STATE] &&
                (req_state == `PMCS_STATE_D0 || req_state == `PMCS_STATE_D3HOT)) begin
                state_next.pm.power_state_field = req_state; // R1 R2 R3 R12
            end
            if (cfg_req.byte_en[`PMCS_LANE_WAKE]) begin
                state_next.pm.wake_event_enable = cfg_req.wdata[`PMCS_WAKE_EN_BIT]; // R4 R12
            end
        end
        if (cfg_req.rd_en) begin
            // Unmapped offsets return zero, so a stray probe is harmless
            state_next.rdata  = hit ? image : `PMCS_ZERO_WORD; // R12
            state_next.rvalid = 1'h1; // R1
        end
        // Reset comes last so that it overrides any access in the same cycle, except a wake enable write while cold_wake is high
        if (reset) begin
            state_next.pm.power_state_field = `PMCS_STATE_D0; // R11
            state_next.rdata                = `PMCS_ZERO_WORD;
            state_next.rvalid               = 1'h0;
            // A reset taken on D3cold wake keeps the enable; only power-off clears it
            if (!cold_wake) begin
                state_next.pm.wake_event_enable = `PMCS_WAKE_EN_RESET; // R5 R11
            end
        end
    end

    // ==========================================================
    // Registers
    // Reset is folded into the next-state logic, so this stays a plain register
    always_ff @(posedge sys_clk) begin
        state_reg <= state_next;
    end

    assign cfg_rdata         = state_reg.rdata;
    assign cfg_rvalid        = state_reg.rvalid;
    assign power_state_field = state_reg.pm.power_state_field;
    assign wake_event_enable = state_reg.pm.wake_event_enable;

    // ==========================================================
    // Checks
    AST_STATE_LEGAL: assert property (@(posedge sys_clk) disable iff (reset)
        power_state_field != `PMCS_STATE_D1 && power_state_field != `PMCS_STATE_D2)
        else $error("power state holds unsupported value"); // R3
    AST_BAD_WRITE_IGNORED: assert property (@(posedge sys_clk) disable iff (reset)
        (cfg_req.wr_en && hit && cfg_req.byte_en[0] &&
         (req_state == `PMCS_STATE_D1 || req_state == `PMCS_STATE_D2))
        |=> $stable(power_state_field))
        else $error("unsupported state write changed state"); // R2
    AST_GOOD_WRITE_TAKEN: assert property (@(posedge sys_clk) disable iff (reset)
        (cfg_req.wr_en && hit && cfg_req.byte_en[0] &&
         (req_state == `PMCS_STATE_D0 || req_state == `PMCS_STATE_D3HOT))
        |=> power_state_field == $past(req_state))
        else $error("supported state write not taken"); // R1
    AST_WAKE_EN_WRITE: assert property (@(posedge sys_clk) disable iff (reset)
        (cfg_req.wr_en && hit && cfg_req.byte_en[1])
        |=> wake_event_enable == $past(cfg_req.wdata[`PMCS_WAKE_EN_BIT]))
        else $error("wake enable write not taken"); // R4
    AST_READ_IMAGE: assert property (@(posedge sys_clk) disable iff (reset)
        (cfg_req.rd_en && hit) |=> cfg_rvalid &&
        cfg_rdata[`PMCS_STATE_MSB:`PMCS_STATE_LSB] == $past(power_state_field) &&
        cfg_rdata[`PMCS_WAKE_EN_BIT] == $past(wake_event_enable) &&
        cfg_rdata[`PMCS_NOSOFT_BIT] == `PMCS_NOSOFT_VALUE)
        else $error("read image wrong"); // R1 R4 R7
    AST_FIXED_BITS: assert property (@(posedge sys_clk) disable iff (reset)
        cfg_rvalid |-> cfg_rdata[`PMCS_SCALE_MSB:`PMCS_SELECT_LSB] == '0 &&
        cfg_rdata[`PMCS_RSVD_LO_MSB:`PMCS_RSVD_LO_LSB] == '0 &&
        cfg_rdata[`PMCS_RSVD_BIT] == 1'h0)
        else $error("read-only bits nonzero"); // R9 R10
    AST_RESET_VALUE: assert property (@(posedge sys_clk)
        reset && !cold_wake |=> power_state_field == `PMCS_STATE_D0 && !wake_event_enable)
        else $error("reset value wrong"); // R11
    AST_COLD_KEEP: assert property (@(posedge sys_clk)
        reset && cold_wake |=> wake_event_enable == $past(wake_event_enable))
        else $error("wake enable lost on cold wake"); // R5
    AST_OTHER_ADDR: assert property (@(posedge sys_clk) disable iff (reset)
        (cfg_req.wr_en && !hit) |=> $stable(power_state_field) && $stable(wake_event_enable))
        else $error("write to other offset changed state"); // R12

    // ==========================================================
    // Fixed fields, read timing and byte lanes
    AST_WAKE_STATUS_ZERO: assert property (@(posedge sys_clk) disable iff (reset)
        cfg_rvalid |-> cfg_rdata[`PMCS_WAKE_ST_BIT] == 1'h0)
        else $error("wake status bit nonzero"); // R6

    AST_DATA_BYTE_ZERO: assert property (@(posedge sys_clk) disable iff (reset)
        cfg_rvalid |-> cfg_rdata[`PMCS_DATA_MSB:`PMCS_DATA_LSB] == '0)
        else $error("power data byte nonzero"); // R8

    AST_SCALE_SELECT_ZERO: assert property (@(posedge sys_clk) disable iff (reset)
        cfg_rvalid |-> cfg_rdata[`PMCS_SCALE_MSB:`PMCS_SCALE_LSB] == '0 &&
        cfg_rdata[`PMCS_SELECT_MSB:`PMCS_SELECT_LSB] == '0)
        else $error("data scale or select nonzero"); // R9

    AST_RESERVED_ZERO: assert property (@(posedge sys_clk) disable iff (reset)
        cfg_rvalid |-> cfg_rdata[`PMCS_RSVD_HI_MSB:`PMCS_RSVD_HI_LSB] == '0 &&
        cfg_rdata[`PMCS_RSVD_LO_MSB:`PMCS_RSVD_LO_LSB] == '0 &&
        cfg_rdata[`PMCS_RSVD_BIT] == 1'h0)
        else $error("reserved bits nonzero"); // R10

    AST_UNMAPPED_ZERO: assert property (@(posedge sys_clk) disable iff (reset)
        (cfg_req.rd_en && !hit) |=> cfg_rvalid && cfg_rdata == `PMCS_ZERO_WORD)
        else $error("unmapped read not zero"); // R12

    AST_RVALID_PULSE: assert property (@(posedge sys_clk) disable iff (reset)
        cfg_rvalid |-> $past(cfg_req.rd_en))
        else $error("read valid without a read"); // R1

    AST_RDATA_HOLDS: assert property (@(posedge sys_clk) disable iff (reset)
        !cfg_req.rd_en |=> $stable(cfg_rdata))
        else $error("read data changed without a read"); // R1

    AST_STATE_QUIET: assert property (@(posedge sys_clk) disable iff (reset)
        !(cfg_req.wr_en && hit) |=> $stable(power_state_field) && $stable(wake_event_enable))
        else $error("state changed without a write"); // R12

    AST_LANE0_OFF: assert property (@(posedge sys_clk) disable iff (reset)
        (cfg_req.wr_en && hit && !cfg_req.byte_en[`PMCS_LANE_STATE])
        |=> $stable(power_state_field))
        else $error("state changed with its lane off"); // R12

    AST_LANE1_OFF: assert property (@(posedge sys_clk) disable iff (reset)
        (cfg_req.wr_en && hit && !cfg_req.byte_en[`PMCS_LANE_WAKE])
        |=> $stable(wake_event_enable))
        else $error("wake enable changed with its lane off"); // R12

    AST_RESET_QUIET: assert property (@(posedge sys_clk)
        reset |=> !cfg_rvalid && cfg_rdata == `PMCS_ZERO_WORD)
        else $error("read outputs not cleared by reset"); // R11

    COV_D3: cover property (@(posedge sys_clk) power_state_field == `PMCS_STATE_D3HOT);
    COV_BAD: cover property (@(posedge sys_clk) cfg_req.wr_en && hit && req_state == `PMCS_STATE_D1);
    COV_WAKE: cover property (@(posedge sys_clk) wake_event_enable);
    COV_COLD: cover property (@(posedge sys_clk) reset && cold_wake && wake_event_enable);
    COV_LANE: cover property (@(posedge sys_clk) cfg_req.wr_en && hit &&
        !cfg_req.byte_en[`PMCS_LANE_STATE] && cfg_req.byte_en[`PMCS_LANE_WAKE]);

endmodule

//--- dv/pmcs_host.sv
// Host software model issuing configuration reads and writes
`timescale 1ns/10ps
module pmcs_host (
    input  wire logic                  sys_clk,
    output pmcs_pkg::pmcs_cfg_req_type cfg_req,
    input  wire logic [31:0]           cfg_rdata,
    input  wire logic                  cfg_rvalid
);
    initial cfg_req = '0;
    // Released lines show an inverted address, inverted byte enables and data after a write and zero byte enables after a read, so a design cannot lean on stale data
    task automatic wr(input logic [11:0] a, input logic [3:0] be, input logic [31:0] d);
        @(posedge sys_clk);
        cfg_req <= '{wr_en: 1'b1, rd_en: 1'b0, addr: a, byte_en: be, wdata: d};
        @(posedge sys_clk);
        cfg_req <= '{wr_en: 1'b0, rd_en: 1'b0, addr: ~a, byte_en: ~be, wdata: ~d};
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic v);
        @(posedge sys_clk);
        cfg_req <= '{wr_en: 1'b0, rd_en: 1'b1, addr: a, byte_en: 4'hF, wdata: 32'h0};
        @(posedge sys_clk);
        cfg_req <= '{wr_en: 1'b0, rd_en: 1'b0, addr: ~a, byte_en: 4'h0, wdata: 32'hF};
        #1;
        d = cfg_rdata;
        v = cfg_rvalid;
    endtask
endmodule

//--- dv/pmcs_power_state_control_bench.sv
// Self-checking bench for the power management control and status register
`timescale 1ns/10ps
module pmcs_power_state_control_bench;
    logic                       sys_clk = 1'b0;
    logic                       reset = 1'b1;
    logic                       cold_wake = 1'b0;
    pmcs_pkg::pmcs_cfg_req_type cfg_req;
    logic [31:0]                cfg_rdata;
    logic                       cfg_rvalid;
    logic [1:0]                 power_state_field;
    logic                       wake_event_enable;
    int                         fail_count = 0;
    int                         cmp_count = 0;
    always #2.5 sys_clk = ~sys_clk;
    pmcs_power_state_control i_pmcs_power_state_control (.sys_clk(sys_clk), .reset(reset),
        .cold_wake(cold_wake), .cfg_req(cfg_req), .cfg_rdata(cfg_rdata),
        .cfg_rvalid(cfg_rvalid), .power_state_field(power_state_field),
        .wake_event_enable(wake_event_enable));
    pmcs_host i_pmcs_host (.sys_clk(sys_clk), .cfg_req(cfg_req), .cfg_rdata(cfg_rdata),
        .cfg_rvalid(cfg_rvalid));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic        v;
        i_pmcs_host.rd(a, d, v);
        chk({31'h0, v}, 32'h1);
        chk(d, exp);
    endtask
    task automatic do_reset(input logic cw);
        @(posedge sys_clk);
        reset <= 1'b1;
        cold_wake <= cw;
        repeat (4) @(posedge sys_clk);
        reset <= 1'b0;
        cold_wake <= 1'b0;
    endtask
    task automatic t_write();
        i_pmcs_host.wr(12'h0A4, 4'hF, 32'h0000_0103);
        rd_chk(12'h0A4, 32'h0000_010B);
        chk({30'h0, power_state_field}, 32'h3);
        chk({31'h0, wake_event_enable}, 32'h1);
        @(posedge sys_clk);
        #1;
        chk({31'h0, cfg_rvalid}, 32'h0);
    endtask
    task automatic t_lanes();
        i_pmcs_host.wr(12'h0A4, 4'h2, 32'h0000_0003);
        rd_chk(12'h0A4, 32'h0000_0008);
        i_pmcs_host.wr(12'h0A4, 4'h1, 32'h0000_0103);
        rd_chk(12'h0A4, 32'h0000_000B);
        i_pmcs_host.wr(12'h0A0, 4'hF, 32'h0000_0100);
        rd_chk(12'h0A4, 32'h0000_000B);
        i_pmcs_host.wr(12'h0A4, 4'h2, 32'h0000_0100);
        rd_chk(12'h0A4, 32'h0000_010B);
    endtask
    task automatic t_refuse();
        i_pmcs_host.wr(12'h0A4, 4'hF, 32'h0000_0101);
        i_pmcs_host.wr(12'h0A4, 4'hF, 32'h0000_0102);
        rd_chk(12'h0A4, 32'h0000_010B);
    endtask
    task automatic t_fixed();
        i_pmcs_host.wr(12'h0A4, 4'hF, 32'hFFFF_FFFC);
        rd_chk(12'h0A4, 32'h0000_0108);
        rd_chk(12'h0A0, 32'h0000_0000);
    endtask
    task automatic t_wake();
        do_reset(1'b1);
        rd_chk(12'h0A4, 32'h0000_0108);
        do_reset(1'b0);
        rd_chk(12'h0A4, 32'h0000_0008);
    endtask
    task automatic stop_test();
        if (fail_count == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        do_reset(1'b0);
        rd_chk(12'h0A4, 32'h0000_0008);
        t_write();
        t_refuse();
        t_fixed();
        t_lanes();
        t_wake();
        stop_test();
    end
    initial begin
        #20000;
        fail_count++;
        stop_test();
    end
endmodule
